// ==== src/mid_pkg.sv ====
package mid_pkg;
    localparam int OP_W = 10;
    localparam logic [9:0] OP_CARRIER_WR = 10'h2A9;
    localparam logic [9:0] OP_NOP = 10'h000;
    localparam logic [9:0] OP_PDOWN = 10'h002;
    localparam logic [9:0] OP_PDOWN_ARM = 10'h05B;
    localparam logic [9:0] OP_PFLAG_SKIP = 10'h003;
    localparam logic [9:0] OP_WDT_RESTART = 10'h2A0;
    localparam logic [9:0] OP_GPREG_TO_AB = 10'h278;
    localparam logic [9:0] OP_AB_TO_GPREG = 10'h238;
    localparam logic [9:0] OP_CLK_RD = 10'h252;
    localparam logic [9:0] OP_CLK_WR = 10'h216;
    localparam logic [9:0] OP_BANK_SET = 10'h041;
    localparam logic [9:0] OP_BANK_CLR = 10'h040;

    // register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam int ADDR_LSB_W = 8;

    // status fields
    localparam int ST_BACKUP = 0;
    localparam int ST_PFLAG = 1;
    localparam int ST_WDF = 2;
    localparam int ST_WEF = 3;
    localparam int ST_BANK = 4;
    localparam int ST_CAR_LO = 5;
    localparam int ST_CAR_HI = 6;
    localparam int ST_CLK_LSB = 8;
    localparam int ST_GP_LSB = 16;

    // control fields, write one to act
    localparam int CT_PFLAG_CLR = 0;
    localparam int CT_WAKE = 1;

    // reset values
    localparam logic [3:0] CLKCTRL_RST = 4'h0;
    localparam logic [7:0] GPREG_RST = 8'h00;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

// ==== src/mid_misc_decode.sv ====
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
module mid_misc_decode
    import mid_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic instr_valid,
    input wire logic [OP_W-1:0] instr,
    input wire logic [3:0] acc_a,
    input wire logic [3:0] acc_b,
    input wire logic wdt_overflow_evt,
    input wire logic wake_pin,
    output logic acc_a_we,
    output logic acc_b_we,
    output logic [3:0] acc_a_out,
    output logic [3:0] acc_b_out,
    output logic skip_next,
    output logic ram_backup_mode,
    output logic power_return_flag,
    output logic carrier_ctrl_hi,
    output logic carrier_ctrl_lo,
    output logic [3:0] clock_control_reg,
    output logic [7:0] gpreg,
    output logic table_page_bit6,
    output logic watchdog_overflow_flag,
    output logic watchdog_enable_flag,
    output logic wdt_restart
);

    // instruction decode
    logic skip_pend_q;
    logic arm_q;
    logic backup_q;
    logic pflag_q;
    wire exec = instr_valid && !skip_pend_q && !backup_q;
    wire consume = instr_valid && !backup_q;
    wire is_car = exec && (instr == OP_CARRIER_WR);
    wire is_pdown = exec && (instr == OP_PDOWN);
    wire is_arm = exec && (instr == OP_PDOWN_ARM);
    wire is_pskip = exec && (instr == OP_PFLAG_SKIP);
    wire is_wdt = exec && (instr == OP_WDT_RESTART);
    wire is_gp2ab = exec && (instr == OP_GPREG_TO_AB);
    wire is_ab2gp = exec && (instr == OP_AB_TO_GPREG);
    wire is_clkrd = exec && (instr == OP_CLK_RD);
    wire is_clkwr = exec && (instr == OP_CLK_WR);
    wire is_bset = exec && (instr == OP_BANK_SET);
    wire is_bclr = exec && (instr == OP_BANK_CLR);
    wire is_nop = exec && (instr == OP_NOP);

    // wake pin synchroniser
    logic wake_s1_q;
    logic wake_s2_q;
    logic wake_s3_q;
    logic wake_lvl_q;
    wire wake_agree = (wake_s2_q == wake_s3_q);
    wire wake_lvl_d = wake_agree ? wake_s3_q : wake_lvl_q;
    wire wake_rise = wake_lvl_d && !wake_lvl_q;

    // bus address phase
    wire bus_go = hsel && hready && ((htrans == HTRANS_NONSEQ) || (htrans == HTRANS_SEQ));
    wire [ADDR_LSB_W-1:0] ofs = haddr[ADDR_LSB_W-1:0];
    logic wr_pend_q;
    logic [ADDR_LSB_W-1:0] wr_ofs_q;
    wire ctrl_wr = wr_pend_q && (wr_ofs_q == OFS_CTRL);
    wire sw_pclr = ctrl_wr && hwdata[CT_PFLAG_CLR];
    wire sw_wake = ctrl_wr && hwdata[CT_WAKE];
    wire wake_req = backup_q && (wake_rise || sw_wake);

    logic car_hi_q;
    logic car_lo_q;
    logic [3:0] clk_q;
    logic [7:0] gp_q;
    logic bank_q;
    logic wdf_q;
    logic wef_q;

    logic [31:0] status_w;
    always_comb
    begin
        status_w = 32'h0000_0000;
        status_w[ST_BACKUP] = backup_q;
        status_w[ST_PFLAG] = pflag_q;
        status_w[ST_WDF] = wdf_q;
        status_w[ST_WEF] = wef_q;
        status_w[ST_BANK] = bank_q;
        status_w[ST_CAR_LO] = car_lo_q;
        status_w[ST_CAR_HI] = car_hi_q;
        status_w[ST_CLK_LSB +: 4] = clk_q;
        status_w[ST_GP_LSB +: 8] = gp_q;
    end
    wire rd_hit = bus_go && !hwrite && (ofs == OFS_STATUS);
    wire [31:0] rdata_d = rd_hit ? status_w : 32'h0000_0000;

    // accumulator answer
    wire [3:0] acc_a_d = is_gp2ab ? gp_q[3:0] : clk_q;
    wire [3:0] acc_b_d = gp_q[7:4];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
            wake_s3_q <= 1'b0;
            wake_lvl_q <= 1'b0;
        end
        else
        begin
            wake_s1_q <= wake_pin;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
            wake_lvl_q <= wake_lvl_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            wr_pend_q <= 1'b0;
            wr_ofs_q <= '0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready)
            begin
                hrdata <= rdata_d;
                wr_pend_q <= bus_go && hwrite;
                wr_ofs_q <= ofs;
            end
        end
    end

    // qualifier and skip sequencing
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            arm_q <= 1'b0;
            skip_pend_q <= 1'b0;
            skip_next <= 1'b0;
        end
        else
        begin
            if (consume)
                arm_q <= is_arm;
            if (consume)
                skip_pend_q <= is_pskip && pflag_q;
            skip_next <= is_pskip && pflag_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            backup_q <= 1'b0;
            pflag_q <= 1'b0;
        end
        else
        begin
            if (is_pdown && arm_q)
                backup_q <= 1'b1;
            else if (wake_req)
                backup_q <= 1'b0;
            if (wake_req)
                pflag_q <= 1'b1;
            else if (sw_pclr)
                pflag_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            car_hi_q <= 1'b0;
            car_lo_q <= 1'b0;
        end
        else
        begin
            if (is_car)
            begin
                car_hi_q <= acc_a[1];
                car_lo_q <= acc_a[0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            clk_q <= CLKCTRL_RST;
        end
        else
        begin
            if (is_clkwr)
                clk_q <= acc_a;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gp_q <= GPREG_RST;
        end
        else
        begin
            if (is_ab2gp)
                gp_q <= {acc_b, acc_a};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bank_q <= 1'b0;
        end
        else
        begin
            if (is_bset)
                bank_q <= 1'b1;
            else if (is_bclr)
                bank_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wdf_q <= 1'b0;
            wef_q <= 1'b0;
            wdt_restart <= 1'b0;
        end
        else
        begin
            // restart clears overflow, enables; overflow event wins
            if (wdt_overflow_evt)
                wdf_q <= 1'b1;
            else if (is_wdt)
                wdf_q <= 1'b0;
            if (is_wdt)
                wef_q <= 1'b1;
            wdt_restart <= is_wdt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc_a_we <= 1'b0;
            acc_b_we <= 1'b0;
            acc_a_out <= 4'h0;
            acc_b_out <= 4'h0;
        end
        else
        begin
            // lower nibble to A, upper to B
            acc_a_we <= is_gp2ab || is_clkrd;
            acc_b_we <= is_gp2ab;
            acc_a_out <= acc_a_d;
            acc_b_out <= acc_b_d;
        end
    end

    assign ram_backup_mode = backup_q;
    assign power_return_flag = pflag_q;
    assign carrier_ctrl_hi = car_hi_q;
    assign carrier_ctrl_lo = car_lo_q;
    assign clock_control_reg = clk_q;
    assign gpreg = gp_q;
    assign table_page_bit6 = bank_q;
    assign watchdog_overflow_flag = wdf_q;
    assign watchdog_enable_flag = wef_q;

endmodule // mid_misc_decode

// ==== tb/mid_misc_decode_assertions.sv ====
`timescale 1ns/100ps
module mid_chk
    import mid_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic acc_b_we,
    input wire logic wdt_restart,
    input wire logic instr_valid,
    input wire logic [OP_W-1:0] instr,
    input wire logic [3:0] acc_a,
    input wire logic [3:0] acc_b,
    input wire logic wdt_overflow_evt,
    input wire logic acc_a_we,
    input wire logic [3:0] acc_a_out,
    input wire logic [3:0] acc_b_out,
    input wire logic skip_next,
    input wire logic ram_backup_mode,
    input wire logic power_return_flag,
    input wire logic carrier_ctrl_hi,
    input wire logic carrier_ctrl_lo,
    input wire logic [3:0] clock_control_reg,
    input wire logic [7:0] gpreg,
    input wire logic table_page_bit6,
    input wire logic watchdog_overflow_flag,
    input wire logic watchdog_enable_flag
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic pend_q;
    logic arm_q;
    // a valid instruction is executed unless it is the one being skipped or RAM backup mode is on
    wire take = instr_valid && !ram_backup_mode;
    wire ex = take && !skip_next && !pend_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_q <= 1'b0;
            arm_q <= 1'b0;
        end
        else
        begin
            pend_q <= skip_next ? !take : (pend_q && !take);
            arm_q <= take ? (ex && (instr == OP_PDOWN_ARM)) : arm_q;
        end
    end
    AST_OKAY: assert property (hreadyout && !hresp) else $error("bus response");
    AST_WDT_PULSE: assert property (ex && instr == OP_WDT_RESTART
        |=> wdt_restart) else $error("watchdog restart pulse");
    AST_CLKRD: assert property (ex && instr == OP_CLK_RD
        |=> acc_a_we && !acc_b_we && acc_a_out == $past(clock_control_reg))
        else $error("clock ctrl read");
    AST_CARRIER: assert property (ex && instr == OP_CARRIER_WR
        |=> {carrier_ctrl_hi, carrier_ctrl_lo} == $past(acc_a[1:0])) else $error("carrier");
    AST_PDOWN: assert property (ex && instr == OP_PDOWN && arm_q
        |=> ram_backup_mode) else $error("power-down");
    AST_SKIP: assert property (ex && instr == OP_PFLAG_SKIP && power_return_flag
        |=> skip_next && $stable(power_return_flag)) else $error("skip");
    AST_WDT: assert property (ex && instr == OP_WDT_RESTART && !wdt_overflow_evt
        |=> !watchdog_overflow_flag && watchdog_enable_flag) else $error("watchdog");
    AST_TOGP: assert property (ex && instr == OP_AB_TO_GPREG
        |=> gpreg == $past({acc_b, acc_a})) else $error("gpreg write");
    AST_FROMGP: assert property (ex && instr == OP_GPREG_TO_AB
        |=> acc_a_we && {acc_b_out, acc_a_out} == $past(gpreg)) else $error("gpreg read");
    AST_CLKWR: assert property (ex && instr == OP_CLK_WR
        |=> clock_control_reg == $past(acc_a)) else $error("clock ctrl");
    AST_BANK: assert property (ex && (instr == OP_BANK_SET || instr == OP_BANK_CLR)
        |=> table_page_bit6 == $past(instr[0])) else $error("bank bit");
endmodule // mid_chk

// ==== tb/misc_instruction_decode_tb.sv ====
`timescale 1ns/100ps
module misc_instruction_decode_tb
    import mid_pkg::*;
;
    typedef struct packed {logic [9:0] op; logic [7:0] ab; logic [31:0] m; logic [31:0] e;} mid_row_t;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, instr_valid = 1'b0;
    logic wdt_overflow_evt = 1'b0, wake_pin = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
    logic [1:0] htrans = 2'h0;
    logic [9:0] instr = 10'h000;
    logic [3:0] acc_a = 4'h0, acc_b = 4'h0;
    wire hreadyout, acc_a_we, acc_b_we;
    wire [31:0] hrdata;
    wire [3:0] acc_a_out, acc_b_out;
    int err_count = 0, num_checks = 0;
    mid_row_t rows [8] = '{'{OP_CLK_WR, 8'h05, 32'hF00, 32'h500},
        '{OP_AB_TO_GPREG, 8'hC3, 32'hFF0000, 32'hC30000},
        '{OP_CARRIER_WR, 8'h02, 32'h60, 32'h40}, '{OP_CARRIER_WR, 8'h01, 32'h60, 32'h20},
        '{OP_BANK_SET, 8'h00, 32'h10, 32'h10}, '{OP_BANK_CLR, 8'h00, 32'h10, 32'h0},
        '{OP_WDT_RESTART, 8'h00, 32'hC, 32'h8}, '{OP_NOP, 8'hFF, 32'hFFFFFFFF, 32'hC30528}};
    mid_misc_decode dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .instr_valid, .instr,
        .acc_a, .acc_b, .wdt_overflow_evt, .wake_pin, .acc_a_we, .acc_b_we, .acc_a_out,
        .acc_b_out, .skip_next(), .ram_backup_mode(), .power_return_flag(), .carrier_ctrl_hi(),
        .carrier_ctrl_lo(), .clock_control_reg(), .gpreg(), .table_page_bit6(),
        .watchdog_overflow_flag(), .watchdog_enable_flag(), .wdt_restart());
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, {24'h0, OFS_STATUS}, 32'h0);
        chk(r & m, e);
    endtask
    task automatic ins(input logic [9:0] op, input logic [7:0] ab);
        instr_valid <= 1'b1;
        instr <= op;
        {acc_b, acc_a} <= ab;
        @(posedge hclk);
    endtask
    task automatic idle();
        instr_valid <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always #5 hclk = ~hclk;
    initial
    begin
        #100000;
        err_count++;
        end_of_test();
    end
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        st(32'hFFFFFFFF, 32'h0);
        wdt_overflow_evt <= 1'b1;
        @(posedge hclk);
        wdt_overflow_evt <= 1'b0;
        st(32'h4, 32'h4);
        foreach (rows[i])
        begin
            ins(rows[i].op, rows[i].ab);
            idle();
            st(rows[i].m, rows[i].e);
        end
        ins(OP_GPREG_TO_AB, 8'h00);
        instr_valid <= 1'b0;
        #1 chk({22'h0, acc_a_we, acc_b_we, acc_b_out, acc_a_out}, 32'h3C3);
        @(posedge hclk);
        ins(OP_CLK_RD, 8'h00);
        instr_valid <= 1'b0;
        #1 chk({26'h0, acc_a_we, acc_b_we, acc_a_out}, 32'h25);
        @(posedge hclk);
        ins(OP_PDOWN_ARM, 8'h00);
        ins(OP_NOP, 8'h00);
        ins(OP_PDOWN, 8'h00);
        idle();
        st(32'h1, 32'h0);
        ins(OP_PDOWN_ARM, 8'h00);
        ins(OP_PDOWN, 8'h00);
        idle();
        st(32'h1, 32'h1);
        ins(OP_CLK_WR, 8'h09);
        idle();
        wake_pin <= 1'b1;
        repeat (8) @(posedge hclk);
        wake_pin <= 1'b0;
        st(32'hF03, 32'h502);
        // the write right behind the skip must be dropped
        ins(OP_PFLAG_SKIP, 8'h00);
        ins(OP_CLK_WR, 8'h0A);
        idle();
        st(32'hF02, 32'h502);
        bus(1'b1, {24'h0, OFS_CTRL}, 32'h1);
        st(32'h2, 32'h0);
        bus(1'b0, 32'h8, 32'h0);
        chk(r, 32'h0);
        end_of_test();
    end
endmodule // misc_instruction_decode_tb
bind mid_misc_decode mid_chk chk_i (.*);
